// ### hdl/power_shutdown_wake_controller.sv
`timescale 1ns/1ps
`include "pwr_consts.svh"

module power_shutdown_wake_controller (
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [7:0]  awaddr_i,
   input  wire logic        awvalid_i,
   output logic             awready_o,
   input  wire logic [31:0] wdata_i,
   input  wire logic [3:0]  wstrb_i,
   input  wire logic        wvalid_i,
   output logic             wready_o,
   output logic [1:0]       bresp_o,
   output logic             bvalid_o,
   input  wire logic        bready_i,
   input  wire logic [7:0]  araddr_i,
   input  wire logic        arvalid_i,
   output logic             arready_o,
   output logic [31:0]      rdata_o,
   output logic [1:0]       rresp_o,
   output logic             rvalid_o,
   input  wire logic        rready_i,
   input  wire logic        wake_input_zero_i,
   input  wire logic        backup_alarm_timer_i,
   output logic             power_off_pin_o,
   output logic             irq_o
);

   localparam pwr_pkg::ctrl_state_t RESET_STATE = '{
      aw_rdy    : 1'b1,
      w_rdy     : 1'b1,
      ar_rdy    : 1'b1,
      edge_sel  : pwr_pkg::edge_sel_t'(`CFG_RESET & 32'h0000_0003),
      default   : '0
   };

   pwr_pkg::ctrl_state_t st_r;
   pwr_pkg::ctrl_state_t st_nxt;
   logic                 do_write;
   logic                 wr_cmd;
   logic                 cmd_ok;
   logic                 key_bad;
   logic                 alarm_rise;
   logic                 alarm_hit;
   logic                 rd_stat;
   logic [31:0]          rd_word;
   logic                 rd_hit;
   logic                 wr_hit;

   // offsets are word aligned, the low two address bits never select
   function automatic logic [7:0] word_addr(input logic [7:0] a);
      return a & 8'hFC;
   endfunction

   wake_if wk ();

   assign wk.edge_sel  = st_r.edge_sel;
   assign wk.deb_count = st_r.deb_count;
   assign wk.wake_in   = wake_input_zero_i;

   wake_filter u_filter (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .wk         (wk.det)
   );

   // ***********************************************
   // read decode
   // ***********************************************
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (word_addr(araddr_i))
         `OFF_CMD: rd_word = 32'h0000_0000;
         `OFF_CFG: begin
            rd_word[`EDGE_MSB:`EDGE_LSB] = st_r.edge_sel;
            rd_word[`DEB_MSB:`DEB_LSB]   = st_r.deb_count;
            rd_word[`ALARM_EN_BIT]       = st_r.alarm_en;
         end
         `OFF_STAT: begin
            rd_word[`FLAG_WAKE_BIT] = st_r.wake_flag;
            rd_word[`FLAG_ALRM_BIT] = st_r.alarm_flag;
         end
         `OFF_IRQ_ST: begin
            rd_word[`FLAG_WAKE_BIT] = st_r.irq_st[0];
            rd_word[`FLAG_ALRM_BIT] = st_r.irq_st[1];
         end
         `OFF_IRQ_MASK: begin
            rd_word[`FLAG_WAKE_BIT] = st_r.irq_mask[0];
            rd_word[`FLAG_ALRM_BIT] = st_r.irq_mask[1];
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      st_nxt     = st_r;
      do_write   = st_r.aw_held && st_r.w_held && !st_r.bvalid;
      wr_cmd     = do_write && word_addr(st_r.awaddr) == `OFF_CMD;
      key_bad    = st_r.wdata[`KEY_MSB:`KEY_LSB] != `KEY_VALUE;
      // key sits in the top byte, so both lanes must be strobed
      cmd_ok     = wr_cmd && !key_bad && st_r.wstrb[3] && st_r.wstrb[0]
                   && st_r.wdata[`PD_BIT];
      rd_stat    = arvalid_i && st_r.ar_rdy && word_addr(araddr_i) == `OFF_STAT;
      wr_hit     = 1'b1;

      // alarm crosses in from the backup timer, two stages then edge
      st_nxt.alarm_s1 = backup_alarm_timer_i;
      st_nxt.alarm_s2 = st_r.alarm_s1;
      st_nxt.alarm_s3 = st_r.alarm_s2;
      alarm_rise      = st_r.alarm_s2 && !st_r.alarm_s3;
      alarm_hit       = alarm_rise && st_r.alarm_en;

      if (awvalid_i && st_r.aw_rdy) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr  = awaddr_i;
      end
      if (wvalid_i && st_r.w_rdy) begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata  = wdata_i;
         st_nxt.wstrb  = wstrb_i;
      end
      if (st_r.bvalid && bready_i) begin
         st_nxt.bvalid = 1'b0;
      end

      if (do_write) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         unique case (word_addr(st_r.awaddr))
            `OFF_CMD: ;
            `OFF_CFG: begin
               if (st_r.wstrb[0]) begin
                  st_nxt.edge_sel  = pwr_pkg::edge_sel_t'(st_r.wdata[`EDGE_MSB:`EDGE_LSB]);
                  st_nxt.deb_count = st_r.wdata[`DEB_MSB:`DEB_LSB];
               end
               if (st_r.wstrb[2]) begin
                  st_nxt.alarm_en = st_r.wdata[`ALARM_EN_BIT];
               end
            end
            `OFF_STAT: ;
            `OFF_IRQ_ST: begin
               if (st_r.wstrb[0] && st_r.wdata[`FLAG_WAKE_BIT]) begin
                  st_nxt.irq_st[0] = 1'b0;
               end
               if (st_r.wstrb[2] && st_r.wdata[`FLAG_ALRM_BIT]) begin
                  st_nxt.irq_st[1] = 1'b0;
               end
            end
            `OFF_IRQ_MASK: begin
               if (st_r.wstrb[0]) begin
                  st_nxt.irq_mask[0] = st_r.wdata[`FLAG_WAKE_BIT];
               end
               if (st_r.wstrb[2]) begin
                  st_nxt.irq_mask[1] = st_r.wdata[`FLAG_ALRM_BIT];
               end
            end
            default: wr_hit = 1'b0;
         endcase
         st_nxt.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      st_nxt.aw_rdy = !st_nxt.aw_held && !st_nxt.bvalid;
      st_nxt.w_rdy  = !st_nxt.w_held && !st_nxt.bvalid;

      if (arvalid_i && st_r.ar_rdy) begin
         st_nxt.ar_rdy = 1'b0;
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = rd_word;
         st_nxt.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (st_r.rvalid && rready_i) begin
         st_nxt.rvalid = 1'b0;
         st_nxt.ar_rdy = 1'b1;
      end

      // two-stage delay keeps the pin from moving in the write cycle
      st_nxt.cmd_d1 = cmd_ok;
      st_nxt.cmd_d2 = st_r.cmd_d1;
      if (st_r.cmd_d2) begin
         st_nxt.pin = 1'b1;
      end else if (wk.wake_fire || alarm_hit) begin
         st_nxt.pin = 1'b0;
      end

      // clear on read first, a same-cycle event then wins
      if (rd_stat) begin
         st_nxt.wake_flag  = 1'b0;
         st_nxt.alarm_flag = 1'b0;
      end
      if (wk.wake_fire) begin
         st_nxt.wake_flag = 1'b1;
         st_nxt.irq_st[0] = 1'b1;
      end
      if (alarm_hit) begin
         st_nxt.alarm_flag = 1'b1;
         st_nxt.irq_st[1]  = 1'b1;
      end
      st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask);
   end

   // free-running clock, nothing gates this process
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= RESET_STATE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ***********************************************
   // outputs
   // ***********************************************
   assign awready_o       = st_r.aw_rdy;
   assign wready_o        = st_r.w_rdy;
   assign bvalid_o        = st_r.bvalid;
   assign bresp_o         = st_r.bresp;
   assign arready_o       = st_r.ar_rdy;
   assign rvalid_o        = st_r.rvalid;
   assign rdata_o         = st_r.rdata;
   assign rresp_o         = st_r.rresp;
   assign power_off_pin_o = st_r.pin;
   assign irq_o           = st_r.irq;

   // ***********************************************
   // checks
   // ***********************************************
   sequence cmd_taken;
      cmd_ok ##1 st_r.cmd_d1;
   endsequence

   sequence pin_follows;
      st_r.cmd_d2 ##1 power_off_pin_o;
   endsequence

   cmd_delay_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      cmd_taken |=> pin_follows)
      else $error("power-off pin not set two cycles after command");

   bad_key_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_cmd && key_bad) |=> !st_r.cmd_d1)
      else $error("command with wrong key was accepted");

   zero_bit_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_cmd && !st_r.wdata[`PD_BIT]) |=> !st_r.cmd_d1)
      else $error("command with power-down bit clear had effect");

   wake_release_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (wk.wake_fire && !st_r.cmd_d2) |=> !power_off_pin_o)
      else $error("wake event did not release power-off pin");

   alarm_release_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (alarm_rise && st_r.alarm_en && !st_r.cmd_d2) |=> (!power_off_pin_o && st_r.alarm_flag))
      else $error("enabled alarm did not release pin");

   alarm_ignore_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (alarm_rise && !st_r.alarm_en && !wk.wake_fire && !st_r.cmd_d2)
      |=> $stable(power_off_pin_o))
      else $error("disabled alarm changed power-off pin");

   pin_hold_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (!power_off_pin_o && !st_r.cmd_d2) |=> !power_off_pin_o)
      else $error("power-off pin rose without accepted command");

   stat_clear_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (rd_stat && !wk.wake_fire) |=> (!st_r.wake_flag && st_r.rvalid))
      else $error("wake flag not cleared by status read");

   flag_set_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      alarm_hit |=> (st_r.alarm_flag ##1 (st_r.alarm_flag || $past(rd_stat))))
      else $error("alarm flag lost after alarm wake");

   irq_level_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (|(st_r.irq_st & st_r.irq_mask)) |-> irq_o)
      else $error("interrupt low with unmasked status set");

   irq_low_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      !(|(st_r.irq_st & st_r.irq_mask)) |-> !irq_o)
      else $error("interrupt high with no unmasked status");

   wake_flag_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      wk.wake_fire |=> st_r.wake_flag)
      else $error("wake event did not set wake flag");

   alarm_quiet_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (alarm_rise && !st_r.alarm_en && !st_r.alarm_flag) |=> !st_r.alarm_flag)
      else $error("disabled alarm set alarm flag");

   fresh_edge_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      alarm_hit |-> ($past(backup_alarm_timer_i, 2) && !$past(backup_alarm_timer_i, 3)))
      else $error("alarm wake without a fresh rising edge");

   cmd_wins_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      st_r.cmd_d2 |=> power_off_pin_o)
      else $error("accepted command did not raise power-off pin");

   cfg_read_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (arvalid_i && arready_o && word_addr(araddr_i) == `OFF_CFG)
      |=> (rdata_o[`ALARM_EN_BIT] == $past(st_r.alarm_en)))
      else $error("configuration read returned wrong alarm enable");

   write_resp_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      do_write |=> (bvalid_o && !awready_o && !wready_o))
      else $error("write response not raised after write");

   b_hold_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (bvalid_o && !bready_i) |=> (bvalid_o && $stable(bresp_o)))
      else $error("write response dropped before bready");

   r_hold_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (rvalid_o && !rready_i) |=> (rvalid_o && $stable(rdata_o)))
      else $error("read data dropped before rready");

endmodule

// ### hdl/pwr_consts.svh
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH

// ***********************************************
// register offsets
// ***********************************************
`define OFF_CMD       8'h00
`define OFF_CFG       8'h04
`define OFF_STAT      8'h08
`define OFF_IRQ_ST    8'h0C
`define OFF_IRQ_MASK  8'h10

// ***********************************************
// field positions and values
// ***********************************************
`define KEY_MSB       31
`define KEY_LSB       24
`define KEY_VALUE     8'hA5
`define PD_BIT        0
`define EDGE_MSB      1
`define EDGE_LSB      0
`define DEB_MSB       7
`define DEB_LSB       4
`define ALARM_EN_BIT  16
`define FLAG_WAKE_BIT 0
`define FLAG_ALRM_BIT 16

// ***********************************************
// reset values, timing and response codes
// ***********************************************
`define CFG_RESET     32'h0000_0003
`define STAT_RESET    32'h0000_0000
`define DEB_UNIT      8'h10
`define CMD_DELAY     2
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ### hdl/pwr_pkg.sv
package pwr_pkg;

   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_sel_t;

   typedef struct packed {
      logic       in_r;
      logic       running;
      logic [7:0] count;
   } filt_state_t;

   typedef struct packed {
      logic        aw_held;
      logic [7:0]  awaddr;
      logic        w_held;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        aw_rdy;
      logic        w_rdy;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        ar_rdy;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      edge_sel_t   edge_sel;
      logic [3:0]  deb_count;
      logic        alarm_en;
      logic        cmd_d1;
      logic        cmd_d2;
      logic        pin;
      logic        alarm_s1;
      logic        alarm_s2;
      logic        alarm_s3;
      logic        wake_flag;
      logic        alarm_flag;
      logic [1:0]  irq_st;
      logic [1:0]  irq_mask;
      logic        irq;
   } ctrl_state_t;

endpackage

// ### hdl/wake_if.sv
`timescale 1ns/1ps
interface wake_if;
   pwr_pkg::edge_sel_t edge_sel;
   logic [3:0]         deb_count;
   logic               wake_in;
   logic               wake_fire;

   modport ctrl (output edge_sel, output deb_count, output wake_in, input wake_fire);
   modport det  (input edge_sel, input deb_count, input wake_in, output wake_fire);
endinterface

// ### hdl/wake_filter.sv
`timescale 1ns/1ps
`include "pwr_consts.svh"

module wake_filter (
   input  wire logic core_clk_i,
   input  wire logic reset_n_i,
   wake_if.det       wk
);

   pwr_pkg::filt_state_t st_r;
   pwr_pkg::filt_state_t st_nxt;
   logic                 change;
   logic                 qual;
   logic                 fire;
   logic [7:0]           target;

   // ***********************************************
   // edge qualification and debounce count
   // ***********************************************
   always_comb begin
      st_nxt = st_r;
      fire   = 1'b0;
      target = 8'(wk.deb_count * `DEB_UNIT);
      change = wk.wake_in != st_r.in_r;
      unique case (wk.edge_sel)
         pwr_pkg::EDGE_NONE: qual = 1'b0;
         pwr_pkg::EDGE_RISE: qual = change && wk.wake_in;
         pwr_pkg::EDGE_FALL: qual = change && !wk.wake_in;
         pwr_pkg::EDGE_BOTH: qual = change;
      endcase
      st_nxt.in_r = wk.wake_in;
      if (change) begin
         // any change aborts a running count
         st_nxt.running = 1'b0;
         st_nxt.count   = 8'h00;
         if (qual && target == 8'h00) begin
            fire = 1'b1;
         end else if (qual) begin
            st_nxt.running = 1'b1;
            st_nxt.count   = 8'h01;
         end
      end else if (st_r.running) begin
         if (st_r.count == target) begin
            fire           = 1'b1;
            st_nxt.running = 1'b0;
            st_nxt.count   = 8'h00;
         end else begin
            st_nxt.count = st_r.count + 8'h01;
         end
      end
   end

   assign wk.wake_fire = fire;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   no_detect_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (wk.edge_sel == pwr_pkg::EDGE_NONE && !st_r.running) |-> !fire)
      else $error("wake fired with detection disabled");

   abort_count_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (st_r.running && change) |=> (!st_r.running || st_r.count == 8'h01))
      else $error("debounce count not cleared on input change");

   fire_count_a: assert property (
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (fire && !change) |-> (st_r.running && st_r.count == target))
      else $error("wake fired before debounce count reached");

endmodule

// ### verification/wake_partner.sv
`timescale 1ns/1ps
// push-button on the wake input, backup alarm, converter behind the pin
module wake_partner (
   input  wire logic core_clk_i,
   input  wire logic power_off_pin_i,
   output logic      wake_o,
   output logic      alarm_o
);
   logic powered;
   // converter runs only while the pin is released
   assign powered = !power_off_pin_i;
   initial begin
      wake_o = 1'b0;
      alarm_o = 1'b0;
   end
   // levels move just after an edge, like a bounced button after filtering
   task press(input logic v);
      @(posedge core_clk_i);
      wake_o <= v;
   endtask
   task ring(input logic v);
      @(posedge core_clk_i);
      alarm_o <= v;
   endtask
endmodule

// ### verification/power_shutdown_wake_controller_test.sv
`timescale 1ns/1ps
`include "pwr_consts.svh"
module power_shutdown_wake_controller_test;
   logic        clk = 1'b0;
   logic        rst_n;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb, lanes;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, pin, irq, wake, alarm;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, v;
   logic        lv = 1'b0;
   logic [1:0]  wq[$];
   logic [33:0] rq[$];
   int          n_errors = 0;
   int          tests_run = 0;
   int          seed = 32'h4788;
   int          m, k;

   always #5 clk = ~clk;

   power_shutdown_wake_controller DUT (
      .core_clk_i(clk), .reset_n_i(rst_n), .awaddr_i(awaddr), .awvalid_i(awvalid),
      .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
      .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
      .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
      .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .wake_input_zero_i(wake),
      .backup_alarm_timer_i(alarm), .power_off_pin_o(pin), .irq_o(irq));

   wake_partner part (.core_clk_i(clk), .power_off_pin_i(pin), .wake_o(wake), .alarm_o(alarm));

   // ***********************************************
   // checking and closing
   // ***********************************************
   task chk(input string s, input logic [33:0] e, input logic [33:0] g);
      tests_run++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", s, e, g);
         n_errors++;
      end
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task timeout(input string s);
      $display("[ERR] %s expected 1 seen 0", s);
      n_errors++;
      give_verdict;
   endtask

   // scoreboard side: oldest note against each answer
   always @(posedge clk) begin
      if (bvalid && bready) begin
         if (wq.size() == 0) chk("bresp_extra", 34'h0, 34'h1);
         else chk("bresp", {32'h0, wq.pop_front()}, {32'h0, bresp});
      end
      if (rvalid && rready) begin
         if (rq.size() == 0) chk("rdata_extra", 34'h0, 34'h1);
         else chk("rdata", rq.pop_front(), {rresp, rdata});
      end
   end

   // ***********************************************
   // bus tasks
   // ***********************************************
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w;
      int i;
      @(posedge clk);
      wq.push_back(r);
      awaddr <= a;
      wdata <= d;
      wstrb <= lanes;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         if (aw && awready) begin
            awvalid <= 1'b0;
            aw = 1'b0;
         end
         if (w && wready) begin
            wvalid <= 1'b0;
            w = 1'b0;
         end
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (i == 40) timeout("bvalid");
   endtask
   task rd(input logic [7:0] a, input logic [33:0] e);
      int i;
      @(posedge clk);
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (i == 40) timeout("rvalid");
   endtask
   task pin_at(input int n, input logic e);
      repeat (n) @(posedge clk);
      #1;
      chk("pin", {33'h0, e}, {33'h0, pin});
   endtask

   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      lanes = 4'hF;
      {rst_n, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
      {awaddr, araddr, wdata, wstrb} <= 52'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      pin_at(1, 1'b0);
      rd(8'h04, {`RESP_OKAY, 32'h0000_0003});
      rd(8'h08, {`RESP_OKAY, 32'h0});
      rd(8'h00, {`RESP_OKAY, 32'h0});
      rd(8'h14, {`RESP_SLVERR, 32'h0});
      wr(8'h14, 32'h1, `RESP_SLVERR);
      wr(8'h08, 32'hFFFF_FFFF, `RESP_OKAY);
      rd(8'h08, {`RESP_OKAY, 32'h0});
      v = $random(seed);
      wr(8'h04, v, `RESP_OKAY);
      rd(8'h04, {`RESP_OKAY, v & 32'h0001_00F3});
      $display("registers done");
      v = $random(seed);
      if (v[31:24] == 8'hA5) v[31:24] = 8'h5A;
      v[0] = 1'b1;
      wr(8'h00, v, `RESP_OKAY);
      pin_at(4, 1'b0);
      wr(8'h00, 32'hA500_0000, `RESP_OKAY);
      pin_at(4, 1'b0);
      // key lane not strobed: the command must not count
      lanes = 4'h1;
      wr(8'h00, 32'hA500_0001, `RESP_OKAY);
      lanes = 4'hF;
      pin_at(4, 1'b0);
      wr(8'h00, 32'hA500_0001, `RESP_OKAY);
      pin_at(0, 1'b0);
      pin_at(1, 1'b1);
      $display("command done");
      wr(8'h04, 32'h0000_0011, `RESP_OKAY);
      part.press(1'b1);
      pin_at(8, 1'b1);
      part.press(1'b0);
      pin_at(20, 1'b1);
      part.press(1'b1);
      pin_at(16, 1'b1);
      pin_at(1, 1'b0);
      chk("converter_on", 34'h1, {33'h0, part.powered});
      part.press(1'b0);
      pin_at(20, 1'b0);
      rd(8'h08, {`RESP_OKAY, 32'h0000_0001});
      rd(8'h08, {`RESP_OKAY, 32'h0});
      $display("debounce done");
      // no debounce, so each mode except none answers its qualifying edge one edge after the change
      for (m = 0; m < 4; m++) begin
         wr(8'h04, {30'h0, m[1:0]}, `RESP_OKAY);
         repeat (2) begin
            wr(8'h00, 32'hA500_0001, `RESP_OKAY);
            pin_at(1, 1'b1);
            lv = !lv;
            part.press(lv);
            pin_at(1, !(m == 3 || (m == 1 && lv) || (m == 2 && !lv)));
         end
      end
      rd(8'h08, {`RESP_OKAY, 32'h0000_0001});
      $display("edge modes done");
      wr(8'h04, 32'h0, `RESP_OKAY);
      wr(8'h00, 32'hA500_0001, `RESP_OKAY);
      part.ring(1'b1);
      part.ring(1'b0);
      pin_at(6, 1'b1);
      rd(8'h08, {`RESP_OKAY, 32'h0});
      wr(8'h04, 32'h0001_0000, `RESP_OKAY);
      part.ring(1'b1);
      k = 0;
      while (pin === 1'b1 && k < 8) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k == 8) timeout("alarm_release");
      chk("alarm_release", 34'h0, {33'h0, pin});
      chk("alarm_delay", 34'h3, 34'(k));
      rd(8'h08, {`RESP_OKAY, 32'h0001_0000});
      // alarm still high: only a fresh rising edge may wake
      wr(8'h00, 32'hA500_0001, `RESP_OKAY);
      pin_at(1, 1'b1);
      pin_at(8, 1'b1);
      part.ring(1'b0);
      $display("alarm done");
      rd(8'h0C, {`RESP_OKAY, 32'h0001_0001});
      chk("irq", 34'h0, {33'h0, irq});
      wr(8'h10, 32'h0000_0001, `RESP_OKAY);
      repeat (2) @(posedge clk);
      #1;
      chk("irq", 34'h1, {33'h0, irq});
      wr(8'h0C, 32'h0000_0001, `RESP_OKAY);
      repeat (2) @(posedge clk);
      #1;
      chk("irq", 34'h0, {33'h0, irq});
      rd(8'h0C, {`RESP_OKAY, 32'h0001_0000});
      $display("interrupts done");
      repeat (2) @(posedge clk);
      give_verdict;
   end
endmodule
